/* File: cmp_unit.sv */
// one compare channel: software match at equality, hardware match one count past
// assumes prev/now describe a single counter step flagged by step
`timescale 1ns/100ps
module cmp_unit
  import hsc_pkg::*;
(
  input  wire logic [CNT_W-1:0] prev,
  input  wire logic [CNT_W-1:0] now,
  input  wire logic [CNT_W-1:0] val,
  input  wire logic             down,
  input  wire logic             hw,
  input  wire logic             step,
  output logic                  match
);

  logic [CNT_W-1:0] past_val;

  always_comb begin
    past_val = down ? val - 1'b1 : val + 1'b1;
    if (hw) begin
      match = step && (prev == val) && (now == past_val);
    end else begin
      match = step && (now == val);
    end
  end

endmodule : cmp_unit

/* File: edge_sync.sv */
// two-flop synchroniser with rise and fall detection for one pin
// assumes the pin is asynchronous to hclk
`timescale 1ns/100ps
module edge_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  always_comb begin
    s_nxt.s1 = pin;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rise = s_r.s2 & ~s_r.s3;
  assign fall = ~s_r.s2 & s_r.s3;

endmodule : edge_sync

/* File: enc_model.sv */
// far side model: encoder pulse pin and the four external interrupt pins
// assumes one request at a time from the bench, sampled on hclk
`timescale 1ns/100ps
module enc_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       req,
  input  wire logic [2:0] which,
  output logic      [4:0] pins,
  output logic            done
);
  logic [3:0] cnt_r;
  logic [2:0] sel_r;

  // pin high four cycles, low eight, so the block's edge sync sees both edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 4'h0;
      sel_r <= 3'h0;
      pins  <= 5'h00;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (cnt_r == 4'h0) begin
        if (req) begin
          cnt_r <= 4'h1;
          sel_r <= which;
        end
      end else begin
        cnt_r       <= cnt_r + 4'h1;
        pins[sel_r] <= (cnt_r < 4'h5);
        if (cnt_r == 4'hC) begin
          cnt_r <= 4'h0;
          done  <= 1'b1;
        end
      end
    end
  end
endmodule : enc_model

/* File: hs_counter_compare_capture.sv */
// high-speed counter with set/reset compare channels, zone compare and edge capture
// assumes an AHB-Lite master on hclk and asynchronous encoder and interrupt pins
`timescale 1ns/100ps
module hs_counter_compare_capture
  import hsc_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire logic [31:0]        hwdata,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic               count_pulse_pin,
  input  wire logic               capture_irq_input_one,
  input  wire logic               capture_irq_input_three,
  input  wire logic               capture_irq_input_four,
  input  wire logic               capture_irq_input_five,
  output logic [FAST_N-1:0]       fast_output_pins,
  output logic [SCAN_N-1:0]       scan_output_pins,
  output logic [ZONE_N-1:0]       zone_out,
  output logic                    result_relay_example,
  output logic                    compare_match_irq_one,
  output logic                    capture_irq_pulse
);

  typedef struct packed {
    ahb_ph_t           ph;
    logic [31:0]       rdata;
    logic              cnt_en;
    logic              dir;
    logic              irq_en;
    logic              fall_sel;
    logic              grp_b;
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  set_val;
    logic [CNT_W-1:0]  rst_val;
    logic [CNT_W-1:0]  zone_lo;
    logic [CNT_W-1:0]  zone_hi;
    chan_cfg_t         set_cfg;
    chan_cfg_t         rst_cfg;
    logic              zone_en;
    logic              relay;
    logic [FAST_N-1:0] fast;
    logic [SCAN_N-1:0] scan_shadow;
    logic [SCAN_N-1:0] scan;
    logic [ZONE_N-1:0] zone;
    logic [CNT_W-1:0]  cap_a;
    logic [CNT_W-1:0]  cap_b;
    logic              cmp_irq;
    logic              cap_irq;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  logic [4:0]       pin_vec;
  logic [4:0]       rise_vec;
  logic [4:0]       fall_vec;
  logic [4:0]       edge_vec;
  logic             step;
  logic [CNT_W-1:0] cnt_step;
  logic             set_match;
  logic             rst_match;
  logic             set_hit;
  logic             rst_hit;
  logic             cap_a_evt;
  logic             cap_b_evt;
  logic             cap_evt;
  logic             data_wr;

  assign pin_vec = {capture_irq_input_five, capture_irq_input_four,
                    capture_irq_input_three, capture_irq_input_one, count_pulse_pin};

  for (genvar g = 0; g < 5; g++) begin : g_sync
    edge_sync u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin     (pin_vec[g]),
      .rise    (rise_vec[g]),
      .fall    (fall_vec[g])
    );
  end

  // capture and reset inputs share the edge selection; the count pin counts on rise
  assign edge_vec = s_r.fall_sel ? fall_vec : rise_vec;
  assign step     = s_r.cnt_en && rise_vec[0];
  assign cnt_step = s_r.dir ? s_r.count - 1'b1 : s_r.count + 1'b1;

  cmp_unit u_set (
    .prev  (s_r.count),
    .now   (cnt_step),
    .val   (s_r.set_val),
    .down  (s_r.dir),
    .hw    (s_r.set_cfg.hw),
    .step  (step),
    .match (set_match)
  );

  cmp_unit u_rst (
    .prev  (s_r.count),
    .now   (cnt_step),
    .val   (s_r.rst_val),
    .down  (s_r.dir),
    .hw    (s_r.rst_cfg.hw),
    .step  (step),
    .match (rst_match)
  );

  assign set_hit   = set_match && s_r.set_cfg.en;
  assign rst_hit   = rst_match && s_r.rst_cfg.en;
  // group A listens to inputs one and four, group B to three and five
  assign cap_a_evt = !s_r.grp_b && (edge_vec[1] || edge_vec[3]);
  assign cap_b_evt = s_r.grp_b && (edge_vec[2] || edge_vec[4]);
  assign cap_evt   = cap_a_evt || cap_b_evt;
  assign data_wr   = s_r.ph.sel && s_r.ph.wr;

  // drive one compare result to its target
  function automatic st_t apply_result(st_t st, chan_cfg_t c, logic v);
    st_t r;
    r = st;
    unique case (c.tgt)
      TGT_RELAY:   r.relay = v;
      TGT_FAST:    r.fast[c.idx] = v;
      TGT_SCAN:    r.scan_shadow[c.idx] = v;
      TGT_IRQ:     r.cmp_irq = 1'b1;
      TGT_COUNTER: if (!v) r.count = CNT_RST;
      default:     r = st;
    endcase
    return r;
  endfunction : apply_result

  function automatic logic [31:0] rd_word(st_t st, logic [ADDR_W-1:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      OFS_CTRL:     w[4:0] = {st.grp_b, st.fall_sel, st.irq_en, st.dir, st.cnt_en};
      OFS_COUNT:    w = st.count;
      OFS_SET_VAL:  w = st.set_val;
      OFS_RST_VAL:  w = st.rst_val;
      OFS_CMP_CFG:  begin
        w[CFG_SET_LSB +: CFG_W] = st.set_cfg;
        w[CFG_RST_LSB +: CFG_W] = st.rst_cfg;
      end
      OFS_ZONE_LO:  w = st.zone_lo;
      OFS_ZONE_HI:  w = st.zone_hi;
      OFS_ZONE_CFG: w[0] = st.zone_en;
      OFS_STATUS:   begin
        w[STA_RELAY] = st.relay;
        w[STA_FAST +: FAST_N] = st.fast;
        w[STA_SCAN +: SCAN_N] = st.scan;
        w[STA_ZONE +: ZONE_N] = st.zone;
      end
      OFS_CAP_A_LO: w[HALF_W-1:0] = st.cap_a[HALF_W-1:0];
      OFS_CAP_A_HI: w[HALF_W-1:0] = st.cap_a[CNT_W-1:HALF_W];
      OFS_CAP_B_LO: w[HALF_W-1:0] = st.cap_b[HALF_W-1:0];
      OFS_CAP_B_HI: w[HALF_W-1:0] = st.cap_b[CNT_W-1:HALF_W];
      default:      w = 32'h0000_0000;
    endcase
    return w;
  endfunction : rd_word

  always_comb begin
    s_nxt = s_r;
    s_nxt.cmp_irq = 1'b0;
    s_nxt.cap_irq = 1'b0;
    // data phase of a write; hardware events below take precedence
    if (data_wr) begin
      unique case (s_r.ph.addr)
        OFS_CTRL: begin
          s_nxt.cnt_en   = hwdata[CTL_CNT_EN];
          s_nxt.dir      = hwdata[CTL_DIR];
          s_nxt.irq_en   = hwdata[CTL_IRQ_EN];
          s_nxt.fall_sel = hwdata[CTL_FALL];
          s_nxt.grp_b    = hwdata[CTL_GRP_B];
        end
        OFS_COUNT:    s_nxt.count = hwdata;
        OFS_SET_VAL:  s_nxt.set_val = hwdata;
        OFS_RST_VAL:  s_nxt.rst_val = hwdata;
        OFS_CMP_CFG:  begin
          s_nxt.set_cfg = hwdata[CFG_SET_LSB +: CFG_W];
          s_nxt.rst_cfg = hwdata[CFG_RST_LSB +: CFG_W];
        end
        OFS_ZONE_LO:  s_nxt.zone_lo = hwdata;
        OFS_ZONE_HI:  s_nxt.zone_hi = hwdata;
        OFS_ZONE_CFG: s_nxt.zone_en = hwdata[0];
        OFS_SCAN_END: s_nxt.scan = s_r.scan_shadow;
        default:      s_nxt.ph = s_r.ph;
      endcase
    end
    // address phase
    s_nxt.ph.sel  = hsel && hready && htrans[1];
    s_nxt.ph.wr   = hwrite;
    s_nxt.ph.addr = haddr[ADDR_W-1:0];
    s_nxt.rdata   = rd_word(s_r, haddr[ADDR_W-1:0]);
    // counting and compare results, reset channel applied last
    if (step) begin
      s_nxt.count = cnt_step;
    end
    if (set_hit) begin
      s_nxt = apply_result(s_nxt, s_r.set_cfg, 1'b1);
    end
    if (rst_hit) begin
      s_nxt = apply_result(s_nxt, s_r.rst_cfg, 1'b0);
    end
    // interrupt use of the inputs wins over plain counter reset
    if (s_r.irq_en) begin
      if (cap_a_evt) begin
        s_nxt.cap_a = s_r.count;
      end
      if (cap_b_evt) begin
        s_nxt.cap_b = s_r.count;
      end
      if (cap_evt) begin
        s_nxt.cap_irq = 1'b1;
        s_nxt.count   = CNT_RST;
      end
    end else if (cap_evt) begin
      s_nxt.count = CNT_RST;
    end
    // zone compare on the present count
    if (!s_r.zone_en) begin
      s_nxt.zone = '0;
    end else if ($signed(s_r.count) < $signed(s_r.zone_lo)) begin
      s_nxt.zone = 3'h1;
    end else if ($signed(s_r.count) > $signed(s_r.zone_hi)) begin
      s_nxt.zone = 3'h4;
    end else begin
      s_nxt.zone = 3'h2;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hrdata                = s_r.rdata;
  assign hreadyout             = 1'b1;
  assign hresp                 = 1'b0;
  assign fast_output_pins      = s_r.fast;
  assign scan_output_pins      = s_r.scan;
  assign zone_out              = s_r.zone;
  assign result_relay_example  = s_r.relay;
  assign compare_match_irq_one = s_r.cmp_irq;
  assign capture_irq_pulse     = s_r.cap_irq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_set_relay_on: assert property (
    set_hit && !rst_hit && s_r.set_cfg.tgt == TGT_RELAY |=> result_relay_example [*2]
      or (result_relay_example && rst_hit && s_r.rst_cfg.tgt == TGT_RELAY))
    else $error("set relay not held on");

  a_rst_relay_off: assert property (
    rst_hit && s_r.rst_cfg.tgt == TGT_RELAY |=> !result_relay_example)
    else $error("reset relay not cleared");

  a_sw_equal: assert property (
    set_hit && !s_r.set_cfg.hw |-> cnt_step == s_r.set_val)
    else $error("software set off equality");

  a_sw_rst_equal: assert property (
    rst_hit && !s_r.rst_cfg.hw |-> cnt_step == s_r.rst_val)
    else $error("software reset off equality");

  a_hw_up_plus: assert property (
    set_hit && s_r.set_cfg.hw && !s_r.dir |-> cnt_step == s_r.set_val + 32'h0000_0001)
    else $error("hardware set not one above");

  a_hw_dn_minus: assert property (
    rst_hit && s_r.rst_cfg.hw && s_r.dir |-> cnt_step == s_r.rst_val - 32'h0000_0001)
    else $error("hardware reset not one below");

  a_irq_launch: assert property (
    set_hit && s_r.set_cfg.tgt == TGT_IRQ |=> compare_match_irq_one ##1 !compare_match_irq_one)
    else $error("compare interrupt pulse wrong");

  a_fast_now: assert property (
    set_hit && !rst_hit && s_r.set_cfg.tgt == TGT_FAST
      |=> fast_output_pins[$past(s_r.set_cfg.idx)])
    else $error("fast pin not set next cycle");

  a_scan_held: assert property (
    !$stable(scan_output_pins) |-> $past(data_wr && s_r.ph.addr == OFS_SCAN_END))
    else $error("scan pin changed outside scan end");

  a_capture_clear: assert property (
    s_r.irq_en && cap_a_evt |=> capture_irq_pulse && s_r.count == CNT_RST
      && s_r.cap_a == $past(s_r.count))
    else $error("group A capture wrong");

  a_capture_grp_b: assert property (
    s_r.irq_en && cap_b_evt |=> capture_irq_pulse && s_r.count == CNT_RST
      && s_r.cap_b == $past(s_r.count))
    else $error("group B capture wrong");

  a_reset_input: assert property (
    !s_r.irq_en && cap_evt |=> s_r.count == CNT_RST && !capture_irq_pulse)
    else $error("reset input did not clear");

  a_match_clear: assert property (
    rst_hit && s_r.rst_cfg.tgt == TGT_COUNTER |=> s_r.count == CNT_RST)
    else $error("reset match did not clear counter");

  a_zone_onehot: assert property (
    s_r.zone_en |=> $onehot(zone_out))
    else $error("zone output not one-hot");

  c_sw_set:   cover property (set_hit && !s_r.set_cfg.hw && s_r.set_cfg.tgt == TGT_RELAY);
  c_hw_reset: cover property (rst_hit && s_r.rst_cfg.hw && s_r.dir);
  c_capture:  cover property (s_r.irq_en && cap_evt);
  c_zone_mid: cover property (zone_out == 3'h2);

endmodule : hs_counter_compare_capture

/* File: hs_counter_compare_capture_tb.sv */
// self-checking bench for the compare and capture block
// assumes a zero-wait slave; the encoder model drives all pins
`timescale 1ns/100ps
module hs_counter_compare_capture_tb;
  import hsc_pkg::*;
  logic              hclk = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel = 1'b0;
  logic              hwrite = 1'b0;
  logic              req = 1'b0;
  logic        [2:0] which = 3'h0;
  logic        [1:0] htrans = 2'h0;
  logic       [31:0] haddr = 32'h0;
  logic       [31:0] hwdata = 32'h0;
  logic       [31:0] hrdata;
  logic       [31:0] rd;
  logic       [31:0] v;
  logic              hready;
  logic              hreadyout;
  logic              hresp;
  logic              done;
  logic              relay;
  logic              cmp_irq;
  logic              cap_irq;
  logic        [4:0] pins;
  logic [FAST_N-1:0] fast;
  logic [SCAN_N-1:0] scan;
  logic [ZONE_N-1:0] zone;
  logic [ADDR_W-1:0] cap_lo;
  integer            n_errors = 0;
  integer            checks_done = 0;
  integer            n_cmp = 0;
  integer            n_cap = 0;
  integer            seed = 32'h3ea86bd3;
  integer            lo;
  integer            hi;
  integer            c;

  assign hready = hreadyout;
  initial forever #20 hclk = ~hclk;

  always @(posedge hclk) begin
    if (cmp_irq === 1'b1) n_cmp <= n_cmp + 1;
    if (cap_irq === 1'b1) n_cap <= n_cap + 1;
  end

  hs_counter_compare_capture u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .count_pulse_pin(pins[0]),
    .capture_irq_input_one(pins[1]), .capture_irq_input_three(pins[2]),
    .capture_irq_input_four(pins[3]), .capture_irq_input_five(pins[4]),
    .fast_output_pins(fast), .scan_output_pins(scan), .zone_out(zone),
    .result_relay_example(relay), .compare_match_irq_one(cmp_irq),
    .capture_irq_pulse(cap_irq)
  );

  enc_model u_enc (
    .hclk(hclk), .hresetn(hresetn), .req(req), .which(which), .pins(pins), .done(done)
  );

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task pulse(input logic [2:0] k);
    @(posedge hclk);
    req   <= 1'b1;
    which <= k;
    @(posedge hclk);
    req <= 1'b0;
    while (done !== 1'b1) @(posedge hclk);
  endtask : pulse

  // one count step up from 99 onto 100 with the given channel setup
  task hit(input logic [31:0] cfg);
    wr(OFS_CMP_CFG, cfg);
    wr(OFS_COUNT, 32'h0000_0063);
    wr(OFS_CTRL, 32'h0000_0001);
    pulse(3'h0);
  endtask : hit

  function automatic logic [2:0] zone_exp(input integer l, input integer h, input integer x);
    if (x < l) return 3'b001;
    if (x > h) return 3'b100;
    return 3'b010;
  endfunction : zone_exp

  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(hresp, 1'b0);
    wr(OFS_SET_VAL, 32'h0000_0064);
    wr(OFS_RST_VAL, 32'h0000_0200);
    hit(32'h0000_4040);
    chk(relay, 1'b1); // set on reaching value
    pulse(3'h0);
    chk(relay, 1'b1); // stays on past value
    wr(OFS_RST_VAL, 32'h0000_0064);
    wr(OFS_CMP_CFG, 32'h0000_4000);
    wr(OFS_CTRL, 32'h0000_0003);
    pulse(3'h0);
    chk(relay, 1'b0); // cleared stepping down onto value
    pulse(3'h0);
    chk(relay, 1'b0); // stays off past value
    hit(32'h0000_2060);
    chk(relay, 1'b0); // hardware ignores equality
    pulse(3'h0);
    chk(relay, 1'b1); // set one count past value
    wr(OFS_CMP_CFG, 32'h0000_6000);
    wr(OFS_COUNT, 32'h0000_0064);
    wr(OFS_CTRL, 32'h0000_0003);
    pulse(3'h0);
    chk(relay, 1'b0); // cleared one count below value
    hit(32'h0000_0046);
    chk(fast, 4'b0100); // fast pin immediate
    hit(32'h0000_0049);
    chk(scan, 4'b0000); // held until scan end
    wr(OFS_SCAN_END, 32'h0000_0000);
    @(posedge hclk);
    chk(scan, 4'b0010); // copied at scan end
    hit(32'h0000_004C);
    chk(n_cmp, 1); // interrupt launched on match
    hit(32'h0000_5000);
    rdc(OFS_COUNT, 32'h0000_0000); // match clears counter
    wr(OFS_ZONE_CFG, 32'h0000_0001);
    for (int i = 0; i < 10; i++) begin
      lo = $random(seed) % 5000;
      hi = lo + ($random(seed) & 1023); // lower bound kept at or below upper
      c  = (i == 0) ? lo : (i == 1) ? hi : (i == 2) ? lo - 1 : (i == 3) ? hi + 1 :
           lo - 600 + ($random(seed) & 2047);
      wr(OFS_ZONE_LO, lo);
      wr(OFS_ZONE_HI, hi);
      wr(OFS_COUNT, c);
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[STA_ZONE +: ZONE_N], zone_exp(lo, hi, c)); // three zone bits
      chk(zone, zone_exp(lo, hi, c)); // exactly one bit set
    end
    for (int k = 1; k < 5; k++) begin
      v      = $random(seed);
      cap_lo = (k % 2 == 0) ? OFS_CAP_B_LO : OFS_CAP_A_LO;
      wr(OFS_CTRL, (k % 2 == 0) ? 32'h0000_0015 : 32'h0000_0005);
      wr(OFS_COUNT, v);
      pulse(k[2:0]); // interrupt use wins over plain reset
      rdc(OFS_COUNT, 32'h0000_0000); // counter cleared after capture
      rdc(cap_lo, {16'h0, v[15:0]}); // low word of pair
      rdc(cap_lo + 8'h04, {16'h0, v[31:16]}); // high word of pair
      chk(n_cap, k); // routine launched once
    end
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL, (k == 0) ? 32'h0000_0009 : 32'h0000_0001);
      wr(OFS_COUNT, 32'h0000_0007);
      pulse(3'h3);
      rdc(OFS_COUNT, 32'h0000_0000); // plain reset on chosen edge
      chk(n_cap, 4); // no capture while interrupt disabled
    end
    wr(8'h3C, 32'hFFFF_FFFF);
    rdc(8'h3C, 32'h0000_0000);
    wr(OFS_ZONE_CFG, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    chk(zone, 3'b000);
    report_and_stop();
  end
endmodule : hs_counter_compare_capture_tb

/* File: hsc_pkg.sv */
// constants, types and register map of the high-speed compare and capture block
// assumes a 32-bit AHB-Lite slave window of 64 bytes
package hsc_pkg;

  localparam int CNT_W  = 32;
  localparam int ADDR_W = 8;
  localparam int HALF_W = 16;
  localparam int FAST_N = 4;
  localparam int SCAN_N = 4;
  localparam int ZONE_N = 3;
  localparam int CFG_W  = 7;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SET_VAL  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RST_VAL  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CMP_CFG  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ZONE_LO  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ZONE_HI  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ZONE_CFG = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CAP_A_LO = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CAP_A_HI = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_CAP_B_LO = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_CAP_B_HI = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_SCAN_END = 8'h34;

  // control register fields
  localparam int CTL_CNT_EN = 0;
  localparam int CTL_DIR    = 1;
  localparam int CTL_IRQ_EN = 2;
  localparam int CTL_FALL   = 3;
  localparam int CTL_GRP_B  = 4;
  // compare configuration fields
  localparam int CFG_SET_LSB = 0;
  localparam int CFG_RST_LSB = 8;
  // status fields
  localparam int STA_RELAY = 0;
  localparam int STA_FAST  = 1;
  localparam int STA_SCAN  = 5;
  localparam int STA_ZONE  = 9;

  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    TGT_RELAY,
    TGT_FAST,
    TGT_SCAN,
    TGT_IRQ,
    TGT_COUNTER
  } target_t;

  typedef struct packed {
    logic       en;
    logic       hw;
    target_t    tgt;
    logic [1:0] idx;
  } chan_cfg_t;

  typedef struct packed {
    logic              sel;
    logic              wr;
    logic [ADDR_W-1:0] addr;
  } ahb_ph_t;

endpackage : hsc_pkg
